// >>> hw/mac_ptp_cfg_pkg.sv
// Purpose: constants and carriers for the MAC TX timing configuration block
// Assumes: classic Wishbone, 32-bit data, byte addresses
// Notes: Operation summary below
// Operation
// - One-step enable turns on timestamp insertion
// - Transparent select enables correction field updates
// - Transparent mode: timer input is correction value
// - Transparent mode: new correction overwrites original; block writes original plus timer plus trim
// - Eleven-bit trim offsets one-step stamp, 3 fraction
// - User preamble enable selects custom preamble
// - Up to 13 clocks ten-lane, 7 four-lane
// - Each receive lane has its own clock
// - Lane width 32 ten-lane, 80 four-lane
// - Single TX core clock for transmit side
// - RX core clock equals TX core clock
// - Switchable build uses ten-lane clock structure
// - Option: one lane clock drives all lanes
package mac_ptp_cfg_pkg;
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_TRIM = 4'h4;
    localparam logic [3:0] OFS_FEC = 4'h8;
    localparam logic [3:0] OFS_STAT = 4'hC;
    localparam int CTRL_ONESTEP = 0;
    localparam int CTRL_TRANSP = 1;
    localparam int CTRL_PREAMBLE = 2;
    localparam int CTRL_TEST_A = 3;
    localparam int CTRL_TEST_B = 4;
    localparam int FEC_FILL_LSB = 0;
    localparam int FEC_THR_LSB = 8;
    localparam int STAT_LANE_LSB = 0;
    localparam int STAT_SHARED = 15;
    localparam int STAT_COUNT_LSB = 16;
    localparam logic [10:0] TRIM_RESET = 11'h2C1;
    localparam logic [1:0] FILL_RESET = 2'h0;
    localparam logic [8:0] THR_RESET = 9'h46;
    localparam int TRIM_FRAC_BITS = 3;
    localparam int CF_FRAC_BITS = 16;
    localparam int MAX_LANES = 10;
    localparam int TEN_LANE_CLOCKS = 13;
    localparam int FOUR_LANE_CLOCKS = 7;
    localparam int WIDTH_TEN_LANE = 32;
    localparam int WIDTH_FOUR_LANE = 80;
    localparam int TIME_W = 64;

    typedef struct packed {
        logic test_b;
        logic test_a;
        logic preamble;
        logic transparent;
        logic onestep;
    } ctrl_t;

    typedef struct packed {
        logic [TIME_W-1:0] timer;
        logic [TIME_W-1:0] orig_cf;
        logic req;
    } stamp_req_t;

    typedef struct packed {
        logic [TIME_W-1:0] value;
        logic valid;
        logic cf_write;
    } stamp_out_t;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        ctrl_t ctrl;
        logic [10:0] trim;
        logic [1:0] fill;
        logic [8:0] thr;
        logic [MAX_LANES-1:0] lane_s1;
        logic [MAX_LANES-1:0] lane_s2;
        stamp_out_t stamp;
        logic [15:0] count;
    } state_t;
endpackage

// >>> hw/mac_ptp_cfg.sv
// Purpose: TX timing options, lane status and register file of the MAC
// Assumes: one 25 MHz clock, classic Wishbone slave, one-cycle ack
// Notes: lane lock pins pass two flip-flops before use
`timescale 1ns/1ps
`default_nettype none
module mac_ptp_cfg #(
    parameter int LANES = 10,
    parameter bit SWITCHABLE = 1'b0,
    parameter bit SHARED_LANE_CLOCK = 1'b0
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [3:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic o_wb_ack,
    output logic [31:0] o_wb_dat,
    // Timestamp request from the transmit path
    input wire mac_ptp_cfg_pkg::stamp_req_t i_req,
    // Timestamp result
    output mac_ptp_cfg_pkg::stamp_out_t o_stamp,
    // Lane lock pins, one per receive lane
    input wire logic [mac_ptp_cfg_pkg::MAX_LANES-1:0] i_lane_lock,
    // Configuration outputs to the transmitter
    output logic o_preamble_enable,
    output logic [1:0] o_fec_fill_trim,
    output logic [8:0] o_fec_marker_threshold
);
    // Ten-lane clocking also serves the switchable build
    localparam int EFF_LANES = SWITCHABLE ? 10 : LANES;
    localparam int CLOCKS = (EFF_LANES == 10) ?
        mac_ptp_cfg_pkg::TEN_LANE_CLOCKS :
        mac_ptp_cfg_pkg::FOUR_LANE_CLOCKS;
    localparam int LANE_W = (EFF_LANES == 10) ?
        mac_ptp_cfg_pkg::WIDTH_TEN_LANE :
        mac_ptp_cfg_pkg::WIDTH_FOUR_LANE;
    localparam int SHIFT =
        mac_ptp_cfg_pkg::CF_FRAC_BITS - mac_ptp_cfg_pkg::TRIM_FRAC_BITS;

    if (LANES != 10 && LANES != 4)
    begin : g_bad_lanes
        $error("LANES must be 10 or 4");
    end
    if (CLOCKS != EFF_LANES + 3 || LANE_W == 0)
    begin : g_bad_clocks
        $error("clock count does not match lane count");
    end

    mac_ptp_cfg_pkg::state_t st;
    mac_ptp_cfg_pkg::state_t next_st;
    logic [mac_ptp_cfg_pkg::MAX_LANES-1:0] lane_mask;
    logic [mac_ptp_cfg_pkg::MAX_LANES-1:0] lane_src;
    logic [mac_ptp_cfg_pkg::TIME_W-1:0] trim_cf;
    logic [31:0] wr_mask;
    logic [31:0] ctrl_word;
    logic [31:0] trim_word;
    logic [31:0] fec_word;
    logic [31:0] stat_word;
    logic [31:0] new_word;
    logic access;

    // Per-lane source: own lane clock domain or lane 0 when shared
    for (genvar g = 0; g < mac_ptp_cfg_pkg::MAX_LANES; g++)
    begin : g_lane
        assign lane_mask[g] = (g < EFF_LANES);
        assign lane_src[g] = SHARED_LANE_CLOCK ?
            i_lane_lock[0] : i_lane_lock[g];
    end

    // Trim in eighths of a ns, aligned to 16 fraction bits
    assign trim_cf = {{(mac_ptp_cfg_pkg::TIME_W-11-SHIFT){1'b0}},
        st.trim, {SHIFT{1'b0}}};

    assign wr_mask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}},
        {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
    assign ctrl_word = {27'h0000000, st.ctrl};
    assign trim_word = {21'h000000, st.trim};
    assign fec_word = {15'h0000, st.thr, 6'h00, st.fill};
    assign stat_word = {st.count, SHARED_LANE_CLOCK, 5'h00,
        st.lane_s2};
    assign access = i_wb_cyc && i_wb_stb && !st.ack;

    always_comb
    begin
        next_st = st;
        new_word = 32'h00000000;
        // Lock flags cross into the core domain
        next_st.lane_s1 = lane_src;
        next_st.lane_s2 = st.lane_s1 & lane_mask;
        next_st.ack = access;
        if (access)
        begin
            unique case (i_wb_adr)
                mac_ptp_cfg_pkg::OFS_CTRL:
                begin
                    next_st.rdata = ctrl_word;
                    new_word = (ctrl_word & ~wr_mask) | (i_wb_dat & wr_mask);
                    if (i_wb_we)
                    begin
                        next_st.ctrl = new_word[4:0];
                    end
                end
                mac_ptp_cfg_pkg::OFS_TRIM:
                begin
                    next_st.rdata = trim_word;
                    new_word = (trim_word & ~wr_mask) | (i_wb_dat & wr_mask);
                    if (i_wb_we)
                    begin
                        next_st.trim = new_word[10:0];
                    end
                end
                mac_ptp_cfg_pkg::OFS_FEC:
                begin
                    next_st.rdata = fec_word;
                    new_word = (fec_word & ~wr_mask) | (i_wb_dat & wr_mask);
                    if (i_wb_we)
                    begin
                        next_st.fill = new_word[1:0];
                        next_st.thr = new_word[16:8];
                    end
                end
                mac_ptp_cfg_pkg::OFS_STAT:
                begin
                    next_st.rdata = stat_word;
                end
                default:
                begin
                    next_st.rdata = 32'h00000000;
                end
            endcase
        end
        // Timestamp result, one cycle after the request
        next_st.stamp.valid = 1'b0;
        next_st.stamp.cf_write = 1'b0;
        if (i_req.req && st.ctrl.onestep)
        begin
            next_st.stamp.valid = 1'b1;
            next_st.count = st.count + 16'h0001;
            if (st.ctrl.transparent)
            begin
                // Timer is a residence correction, added to original
                next_st.stamp.value =
                    i_req.orig_cf + i_req.timer + trim_cf;
                next_st.stamp.cf_write = 1'b1;
            end
            else
            begin
                next_st.stamp.value = i_req.timer + trim_cf;
            end
        end
    end

    // One core clock serves transmit, receive and control sides
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            st <= '0;
            st.trim <= mac_ptp_cfg_pkg::TRIM_RESET;
            st.fill <= mac_ptp_cfg_pkg::FILL_RESET;
            st.thr <= mac_ptp_cfg_pkg::THR_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign o_wb_ack = st.ack;
    assign o_wb_dat = st.rdata;
    assign o_stamp = st.stamp;
    assign o_preamble_enable = st.ctrl.preamble;
    assign o_fec_fill_trim = st.fill;
    assign o_fec_marker_threshold = st.thr;
endmodule
`default_nettype wire

// >>> testbench/mac_ptp_cfg_properties.sv
// Purpose: port checker for mac_ptp_cfg
// Assumes: trim is written as a whole word
// Notes: bound after the module
`timescale 1ns/1ps
`default_nettype none
module mac_ptp_cfg_properties (
    // Clock and bus
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [3:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic o_wb_ack,
    // Stamp path
    input wire mac_ptp_cfg_pkg::stamp_req_t i_req,
    input wire mac_ptp_cfg_pkg::stamp_out_t o_stamp,
    input wire logic o_preamble_enable
);
    logic [10:0] trim;
    logic [63:0] add;
    logic take;
    assign take = i_wb_cyc && i_wb_stb && !o_wb_ack;
    assign add = {53'h0, trim} << 13;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    // Shadow of the trim register
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            trim <= 11'h2C1;
        else if (take && i_wb_we && i_wb_adr == 4'h4)
            trim <= i_wb_dat[10:0];
    end
    property p_ack; take |=> o_wb_ack; endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    property p_ack1; o_wb_ack |=> !o_wb_ack; endproperty
    a_ack1: assert property (p_ack1) else $error("ack too long");
    property p_cause; o_stamp.valid |-> $past(i_req.req); endproperty
    a_cause: assert property (p_cause) else $error("stray stamp");
    property p_cf; o_stamp.cf_write |-> o_stamp.valid; endproperty
    a_cf: assert property (p_cf) else $error("stray cf write");
    property p_hold; !o_stamp.valid |-> $stable(o_stamp.value); endproperty
    a_hold: assert property (p_hold) else $error("stamp moved");
    property p_pre; $changed(o_preamble_enable) |-> o_wb_ack &&
        $past(i_wb_we) && $past(i_wb_adr) == 4'h0; endproperty
    a_pre: assert property (p_pre) else $error("preamble moved");
    property p_norm; o_stamp.valid && !o_stamp.cf_write |->
        o_stamp.value == $past(i_req.timer) + $past(add); endproperty
    a_norm: assert property (p_norm) else $error("bad stamp");
    property p_tc; o_stamp.cf_write |-> o_stamp.value ==
        $past(i_req.orig_cf) + $past(i_req.timer) + $past(add); endproperty
    a_tc: assert property (p_tc) else $error("bad correction");
endmodule
bind mac_ptp_cfg mac_ptp_cfg_properties chk (.i_clk, .i_arst_n,
    .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_dat, .o_wb_ack,
    .i_req, .o_stamp, .o_preamble_enable);
`default_nettype wire

// >>> testbench/stamp_source.sv
// Purpose: transmit path model issuing timestamp requests
// Assumes: timer and correction in ns times 2^16
// Notes: fields invert once released
`timescale 1ns/1ps
`default_nettype none
module stamp_source (
    // Clock
    input wire logic i_clk,
    // Request to the block
    output var mac_ptp_cfg_pkg::stamp_req_t o_req
);
    initial o_req = '0;
    task automatic send(input logic [63:0] t, input logic [63:0] cf);
        o_req <= '{timer: t, orig_cf: cf, req: 1'h1};
        @(posedge i_clk);
    endtask
    task automatic idle();
        o_req <= '{timer: ~o_req.timer, orig_cf: ~o_req.orig_cf, req: 1'h0};
        @(posedge i_clk);
    endtask
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// Purpose: self-checking bench for mac_ptp_cfg
// Assumes: 25 MHz clock, full-word bus writes
// Notes: ten lanes with a static lock pattern
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic i_clk = 1'h0;
    logic i_arst_n = 1'h0;
    logic cyc = 1'h0;
    logic we = 1'h0;
    logic [3:0] adr = 4'h0;
    logic [31:0] dat = 32'h0;
    logic ack;
    logic [31:0] rdat;
    logic [31:0] rd;
    logic pre;
    logic [1:0] fill;
    logic [8:0] thr;
    logic [9:0] lock = 10'h2A5;
    mac_ptp_cfg_pkg::stamp_req_t req;
    mac_ptp_cfg_pkg::stamp_out_t stamp;
    int n_mismatch = 0;
    int comparisons = 0;
    // Core clock scaled down; no reconfiguration clock
    always #20 i_clk = ~i_clk;
    stamp_source src (.i_clk, .o_req(req));
    mac_ptp_cfg dut (.i_clk, .i_arst_n, .i_wb_cyc(cyc), .i_wb_stb(cyc),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(dat),
        .o_wb_ack(ack), .o_wb_dat(rdat), .i_req(req), .o_stamp(stamp),
        .i_lane_lock(lock), .o_preamble_enable(pre),
        .o_fec_fill_trim(fill), .o_fec_marker_threshold(thr));
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [63:0] exp, input logic [63:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t exp %h got %h", $time, exp, got);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        cyc <= 1'h1;
        we <= w;
        adr <= a;
        dat <= d;
        @(posedge i_clk);
        while (ack !== 1'h1)
            @(posedge i_clk);
        rd = rdat;
        cyc <= 1'h0;
        @(posedge i_clk);
    endtask
    task automatic t_reset();
        wb(1'h0, 4'h0, 32'h0);
        chk(32'h0, rd);
        wb(1'h0, 4'h4, 32'h0);
        chk(32'h2C1, rd);
        wb(1'h0, 4'h8, 32'h0);
        chk(32'h4600, rd);
        chk({pre, fill, thr}, {1'h0, 2'h0, 9'h46});
        wb(1'h0, 4'hC, 32'h0);
        chk({22'h0, lock}, rd);
        $display("reset test done");
    endtask
    task automatic t_regs();
        wb(1'h1, 4'h0, 32'h4);
        chk(1'h1, pre);
        wb(1'h1, 4'h2, 32'hFF);
        wb(1'h0, 4'h2, 32'h0);
        chk(32'h0, rd);
        wb(1'h1, 4'h0, 32'h0);
        chk(1'h0, pre);
        $display("register test done");
    endtask
    task automatic t_stamp();
        src.send(64'h1000, 64'h0);
        src.idle();
        chk(1'h0, stamp.valid);
        wb(1'h1, 4'h0, 32'h1);
        src.send(64'h10000, 64'h5);
        src.send(64'h20000, 64'h6);
        chk(2'h2, {stamp.valid, stamp.cf_write});
        chk(64'h10000 + (64'h2C1 << 13), stamp.value);
        src.idle();
        chk(64'h20000 + (64'h2C1 << 13), stamp.value);
        wb(1'h0, 4'hC, 32'h0);
        chk(16'h2, rd[31:16]);
        $display("stamp test done");
    endtask
    task automatic t_transp();
        wb(1'h1, 4'h0, 32'h3);
        wb(1'h1, 4'h4, 32'h322);
        src.send(64'h30000, 64'h70000);
        src.idle();
        chk(1'h1, stamp.cf_write);
        chk(64'hA0000 + (64'h322 << 13), stamp.value);
        $display("transparent test done");
    endtask
    initial
    begin
        repeat (8) @(posedge i_clk);
        i_arst_n <= 1'h1;
        @(posedge i_clk);
        t_reset();
        t_regs();
        t_stamp();
        t_transp();
        tally_and_finish();
    end
    initial
    begin
        repeat (2000) @(posedge i_clk);
        n_mismatch++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
